// ==== sgt_guard_timer.sv ====
// system guard timer with an axi4-lite register slave
// How it works
// - timeout codes: 0 off, 1..3 250ms..1s, 4 reserved, 5..7 2s..8s.
// - a code in effect other than 0 or the reserved 4 starts the counter running.
// - reaching the selected period raises a full system reset.
// - a feed restarts the counter from zero at any moment.
// - writing 0x05 to the feed register is the feed.
// - a control write counts only within 30 us after a feed.
// - control writes outside that window are ignored, code unchanged.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`include "sgt_defines.svh"
module sgt_guard_timer #(
  parameter logic [63:0] UNIT_CYCLES = `SGT_PERIOD_250MS_CYCLES,
  parameter int WINDOW_CYCLES = `SGT_WINDOW_CYCLES,
  parameter int SYSRESET_CYCLES = `SGT_SYSRESET_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic system_reset,
  output sgt_pkg::sgt_code_t timeout_code
);
  import sgt_pkg::*;

  // refused at elaboration: the window needs one cycle, and the pulse count
  // lives in an eight-bit down-counter, so it must fit in 1..255
  if (WINDOW_CYCLES < 1 || SYSRESET_CYCLES < 1 || SYSRESET_CYCLES > 255) begin : g_bad_param
    $error("sgt_guard_timer: window or reset pulse length out of range");
  end

  // write channel holding registers
  logic aw_have_reg, aw_have_next;
  logic [31:0] aw_addr_reg, aw_addr_next;
  logic w_have_reg, w_have_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  sgt_wr_state_t wr_state_reg, wr_state_next;
  logic [1:0] bresp_reg, bresp_next;
  // read channel
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  // guard state
  sgt_code_t code_reg, code_next;
  logic [31:0] window_reg, window_next;
  logic [7:0] sysrst_reg, sysrst_next;
  logic feed_ok;
  logic do_write;
  logic expired;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    hit = (a[31:2] == off[31:2]);
  endfunction : hit

  assign s_axi_awready = (wr_state_reg == SGT_WR_IDLE) && !aw_have_reg;
  assign s_axi_wready = (wr_state_reg == SGT_WR_IDLE) && !w_have_reg;
  assign s_axi_bvalid = (wr_state_reg == SGT_WR_RESP);
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign system_reset = (sysrst_reg != 8'd0);
  assign timeout_code = code_reg;

  assign do_write = aw_have_reg && w_have_reg && (wr_state_reg == SGT_WR_IDLE);
  // the key sits in the low byte, so lane 0 must be written for it to count
  assign feed_ok = do_write && hit(aw_addr_reg, `SGT_OFF_FEED) && w_strb_reg[0]
                   && (w_data_reg[7:0] == `SGT_FEED_KEY);

  always_comb begin
    aw_have_next = aw_have_reg;
    aw_addr_next = aw_addr_reg;
    w_have_next = w_have_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    wr_state_next = wr_state_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    case (wr_state_reg)
      SGT_WR_IDLE: begin
        if (do_write) begin
          aw_have_next = 1'b0;
          w_have_next = 1'b0;
          wr_state_next = SGT_WR_RESP;
          if (hit(aw_addr_reg, `SGT_OFF_CONTROL) || hit(aw_addr_reg, `SGT_OFF_FEED)) begin
            bresp_next = `SGT_RESP_OKAY;
          end else begin
            bresp_next = `SGT_RESP_SLVERR;
          end
        end
      end
      SGT_WR_RESP: begin
        if (s_axi_bready) begin
          wr_state_next = SGT_WR_IDLE;
        end
      end
      default: wr_state_next = SGT_WR_IDLE;
    endcase
  end

  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rdata_next = 32'h0000_0000;
      rresp_next = `SGT_RESP_OKAY;
      if (hit(s_axi_araddr, `SGT_OFF_CONTROL)) begin
        rdata_next = {29'h0000_0000, code_reg};
      end else if (hit(s_axi_araddr, `SGT_OFF_FEED)) begin
        rdata_next = 32'h0000_0000; // write-only, reads as zero
      end else begin
        rresp_next = `SGT_RESP_SLVERR;
      end
    end
  end

  always_comb begin
    code_next = code_reg;
    window_next = window_reg;
    sysrst_next = sysrst_reg;
    if (window_reg != 32'd0) begin
      window_next = window_reg - 32'd1;
    end
    if (feed_ok) begin
      window_next = 32'(WINDOW_CYCLES);
    end else if (do_write && hit(aw_addr_reg, `SGT_OFF_CONTROL) && w_strb_reg[0]) begin
      // a control write outside the window leaves the code alone
      if (window_reg != 32'd0) begin
        code_next = w_data_reg[2:0];
        window_next = 32'd0;
      end
    end
    if (sysrst_reg != 8'd0) begin
      sysrst_next = sysrst_reg - 8'd1;
    end else if (expired) begin
      sysrst_next = 8'(SYSRESET_CYCLES);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 32'h0000_0000;
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      wr_state_reg <= SGT_WR_IDLE;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'h0;
      code_reg <= `SGT_CODE_RESET;
      window_reg <= 32'd0;
      sysrst_reg <= 8'd0;
    end else begin
      aw_have_reg <= aw_have_next;
      aw_addr_reg <= aw_addr_next;
      w_have_reg <= w_have_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      wr_state_reg <= wr_state_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      code_reg <= code_next;
      window_reg <= window_next;
      sysrst_reg <= sysrst_next;
    end
  end

  // the counter is held while the system reset pulse is out
  sgt_counter #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_counter (
    .clk_sys(clk_sys),
    .reset(reset),
    .code(code_reg),
    .clear(feed_ok || system_reset),
    .expired(expired)
  );
endmodule : sgt_guard_timer

// ==== sgt_defines.svh ====
// register offsets, field layouts and timing constants of the system guard timer
`ifndef SGT_DEFINES_SVH
`define SGT_DEFINES_SVH

`define SGT_ADDR_W 32
`define SGT_OFF_CONTROL 32'h2380_0000
`define SGT_OFF_FEED 32'h23c0_0000
`define SGT_FEED_KEY 8'h05
`define SGT_CODE_W 3
`define SGT_CODE_RESET 3'h0
`define SGT_CODE_RESERVED 3'h4
`define SGT_CLK_MHZ 200
`define SGT_WINDOW_US 30
`define SGT_WINDOW_CYCLES ((`SGT_WINDOW_US) * (`SGT_CLK_MHZ))
`define SGT_PERIOD_250MS_CYCLES 64'd50000000
`define SGT_SYSRESET_CYCLES 16
`define SGT_RESP_OKAY 2'h0
`define SGT_RESP_SLVERR 2'h2

`endif

// ==== sgt_pkg.sv ====
// types shared by the system guard timer files
package sgt_pkg;
  typedef logic [2:0] sgt_code_t;
  typedef enum logic [1:0] {
    SGT_WR_IDLE,
    SGT_WR_RESP
  } sgt_wr_state_t;
endpackage : sgt_pkg

// ==== sgt_counter.sv ====
// expiry counter of the system guard timer
`timescale 1ns/1ps
`include "sgt_defines.svh"
module sgt_counter #(
  parameter logic [63:0] UNIT_CYCLES = `SGT_PERIOD_250MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire sgt_pkg::sgt_code_t code,
  input wire logic clear,
  output logic expired
);
  import sgt_pkg::*;

  logic [63:0] count_reg;
  logic [63:0] count_next;
  logic [63:0] limit;

  // refused at elaboration: a zero unit would make every code look disabled
  if (UNIT_CYCLES == 64'd0) begin : g_bad_unit
    $error("sgt_counter: UNIT_CYCLES must be nonzero");
  end

  // code n (n=1..3) is 250 ms << (n-1); codes 5..7 are 250 ms << (n-2) since 4 is reserved
  function automatic logic [63:0] period_of(input sgt_code_t c);
    case (c)
      3'h1: period_of = UNIT_CYCLES;
      3'h2: period_of = UNIT_CYCLES << 1;
      3'h3: period_of = UNIT_CYCLES << 2;
      3'h5: period_of = UNIT_CYCLES << 3;
      3'h6: period_of = UNIT_CYCLES << 4;
      3'h7: period_of = UNIT_CYCLES << 5;
      default: period_of = 64'd0;
    endcase
  endfunction : period_of

  always_comb begin
    limit = period_of(code);
    expired = 1'b0;
    count_next = count_reg;
    if (limit == 64'd0 || clear) begin
      count_next = 64'd0;
    end else if (count_reg + 64'd1 >= limit) begin
      expired = 1'b1;
      count_next = 64'd0;
    end else begin
      count_next = count_reg + 64'd1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count_reg <= 64'd0;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule : sgt_counter

// ==== sgt_guard_timer_sva.sv ====
// assertion checker of the system guard timer
`timescale 1ns/1ps
`include "sgt_defines.svh"
module sgt_guard_timer_sva (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic system_reset,
  input wire sgt_pkg::sgt_code_t timeout_code
);
  import sgt_pkg::*;
  localparam logic [31:0] CTL_ADDR = `SGT_OFF_CONTROL;
  localparam logic [31:0] FEED_ADDR = `SGT_OFF_FEED;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  AST_SRST_LEN: assert property ($rose(system_reset) |->
    system_reset[*8] ##1 system_reset[*8] ##1 !system_reset) else $error("reset pulse length");
  AST_OFF_QUIET: assert property ($rose(system_reset) |->
    !($past(timeout_code) inside {3'h0, 3'h4})) else $error("expiry while disabled");
  AST_CODE_WR: assert property ($changed(timeout_code) |->
    $rose(s_axi_bvalid)) else $error("code changed without write");
  AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  AST_R_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  AST_RD_ERR: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[31:2] != CTL_ADDR[31:2] && s_axi_araddr[31:2] != FEED_ADDR[31:2]
    |=> s_axi_rresp == `SGT_RESP_SLVERR) else $error("unmapped read not refused");
  AST_RD_CODE: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == `SGT_OFF_CONTROL |=> s_axi_rdata == {29'h0, $past(timeout_code)})
    else $error("control read wrong");
  cover property ($rose(system_reset));
  cover property ($changed(timeout_code));
  cover property (s_axi_bvalid && s_axi_bresp == `SGT_RESP_SLVERR);
endmodule : sgt_guard_timer_sva
bind sgt_guard_timer sgt_guard_timer_sva i_sgt_guard_timer_sva (
  .clk_sys(clk_sys),
  .reset(reset),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .system_reset(system_reset),
  .timeout_code(timeout_code)
);

// ==== sgt_guard_timer_tb.sv ====
// self-checking bench of the system guard timer
`timescale 1ns/1ps
`include "sgt_defines.svh"
module sgt_guard_timer_tb;
  import sgt_pkg::*;
  localparam logic [31:0] CTL = `SGT_OFF_CONTROL;
  localparam logic [31:0] FD = `SGT_OFF_FEED;
  logic clk_sys = 0;
  logic reset = 1;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rd;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, system_reset;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  sgt_code_t timeout_code;
  int err_total = 0, n_compared = 0, cyc = 0, rises = 0;
  // short unit and window keep every timeout within a few hundred cycles
  sgt_guard_timer #(.UNIT_CYCLES(64'd20), .WINDOW_CYCLES(50)) i_sgt_guard_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .system_reset(system_reset),
    .timeout_code(timeout_code)
  );
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if ($rose(system_reset)) rises <= rises + 1;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // response ready is raised late on purpose so the slave must hold its answer
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1;
    w = 1;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (aw || w) begin
      @(negedge clk_sys);
      if (s_axi_awready) aw = 0;
      if (s_axi_wready) w = 0;
      @(posedge clk_sys);
      if (!aw) s_axi_awvalid <= 0;
      if (!w) s_axi_wvalid <= 0;
    end
    do @(negedge clk_sys); while (!s_axi_bvalid);
    @(posedge clk_sys);
    s_axi_bready <= 1;
    @(negedge clk_sys);
    rs = s_axi_bresp;
    @(posedge clk_sys);
    s_axi_bready <= 0;
  endtask : wr
  task rdr(input logic [31:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(negedge clk_sys); while (!s_axi_arready);
    @(posedge clk_sys);
    s_axi_arvalid <= 0;
    do @(negedge clk_sys); while (!s_axi_rvalid);
    @(posedge clk_sys);
    s_axi_rready <= 1;
    @(negedge clk_sys);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge clk_sys);
    s_axi_rready <= 0;
  endtask : rdr
  task t_lock;
    rdr(CTL);
    chk("code after reset", 0, rd);
    wr(CTL, 1);
    rdr(CTL);
    chk("unfed control", 0, rd);
    wr(FD, 6);
    wr(CTL, 1);
    rdr(CTL);
    chk("wrong key", 0, rd);
    wr(FD, 5);
    repeat (60) @(posedge clk_sys);
    wr(CTL, 3);
    rdr(CTL);
    chk("late control", 0, rd);
    wr(32'h0, 0);
    chk("unmapped bresp", 2, rs);
    rdr(32'h0);
    chk("unmapped rresp", 2, rs);
  endtask : t_lock
  task t_codes;
    int p, t0;
    for (int c = 1; c < 8; c++) begin
      // the previous expiry pulse must be over, or the wait below ends at once
      while (system_reset) @(negedge clk_sys);
      wr(FD, 5);
      wr(CTL, c);
      t0 = cyc;
      rdr(CTL);
      chk("code read", c, rd);
      chk("code in effect", c, timeout_code);
      p = (c == 4) ? 0 : 20 << ((c < 4) ? c - 1 : c - 2);
      while (!system_reset && cyc - t0 < 700) @(negedge clk_sys);
      chk("expiry", (p != 0), system_reset);
      if (p != 0) chk("period", 1, (cyc - t0 <= p) && (cyc - t0 + 12 >= p));
    end
  endtask : t_codes
  task t_feed;
    int n;
    while (system_reset) @(negedge clk_sys);
    wr(FD, 5);
    wr(CTL, 1);
    n = rises;
    repeat (8) wr(FD, 5);
    chk("fed expiries", n, rises);
  endtask : t_feed
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 0;
    t_lock();
    t_codes();
    t_feed();
    report_and_stop();
  end
endmodule : sgt_guard_timer_tb
